// File: verilog/clkdiv_pkg.sv
// Constants, types and register layout of the sample clock controller
package clkdiv_pkg;
  // Register addresses
  localparam logic [8:0] ADDR_POWER  = 9'h008;
  localparam logic [8:0] ADDR_DCS    = 9'h009;
  localparam logic [8:0] ADDR_DIVIDE = 9'h00B;
  localparam logic [8:0] ADDR_SYNC   = 9'h100;
  // Field positions
  localparam int SYNC_EN_BIT    = 1;
  localparam int SYNC_FIRST_BIT = 2;
  localparam int SYNC_ARMED_BIT = 3;
  localparam int DCS_EN_BIT     = 0;
  localparam int DCS_LOCK_BIT   = 1;
  localparam int DIV_LSB        = 0;
  localparam int PWR_LSB        = 0;
  // Reset values
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic       DCS_RESET  = 1'b0;
  localparam logic [2:0] DIV_RESET  = 3'h0;
  // Timing
  localparam longint SYS_CLK_HZ     = 40_000_000;
  localparam longint DCS_MIN_HZ     = 20_000_000;
  localparam longint DCS_RELOCK_NS  = 5_000;
  localparam int     DCS_RELOCK_CYC =
    int'(DCS_RELOCK_NS * SYS_CLK_HZ / 1_000_000_000);
  localparam int     PD_CNT_W       = 16;
  localparam int     WAKE_SHIFT_FULL = 2;
  localparam int     WAKE_SHIFT_STBY = 4;

  typedef enum logic [1:0] {
    PWR_NORMAL  = 2'b00,
    PWR_FULL    = 2'b01,
    PWR_STANDBY = 2'b10
  } pwr_mode_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_DOWN = 2'b01,
    ST_WAKE = 2'b10
  } pwr_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ref_on;
    logic ref_buf_on;
    logic bias_on;
    logic core_clk_on;
    logic out_oe_n;
  } pwr_ctrl_t;

  typedef struct packed {
    logic [2:0]          sync_s;
    logic                sync_lvl;
    logic [2:0]          pd_s;
    logic                pd_lvl;
    logic [7:0]          sync_ctrl;
    logic                armed;
    logic                duty_cycle_stabiliser;
    logic [2:0]          ratio_m1;
    pwr_mode_t           pwr_mode;
    logic [2:0]          div_cnt;
    logic                conv_clk;
    logic                conv_clk_en;
    logic [7:0]          lock_cnt;
    logic                dcs_locked;
    pwr_state_t          pstate;
    logic                down_stby;
    logic [PD_CNT_W-1:0] pd_time;
    logic [PD_CNT_W-1:0] wake_cnt;
    pwr_ctrl_t           pwr;
    logic                core_ready;
    logic [7:0]          rdata;
  } state_t;
endpackage : clkdiv_pkg

// File: verilog/sample_clock_ctrl.sv
// Sample clock divider, sync realignment, duty stabiliser and power states
// Notes on behaviour
// R1: The conversion clock is the sample clock divided by a ratio of 1 to 8.
// R2: Software should enable the duty stabiliser for ratios other than 1, 2, 4.
// R3: Bits 1 and 2 of divider_sync_control pick realign on every or first sync.
// R4: An accepted sync returns the divider counter to its initial state.
// R5: The sync input is synchronised to the sample clock before use.
// R6: The sync source should drive its pulse synchronous to the sample clock.
// R7: The duty stabiliser keeps the rising edge and makes a half-period high; for odd ratios the code holds it high (ratio + 1) / 2 cycles.
// R8: The duty stabiliser need not run for sample clocks below 20 MHz.
// R9: Software waits 1.5 to 5 us after a clock change before relying on lock.
// R10: Power-down is entered by the power-down pin high or by register.
// R11: While powered down all output drivers are high impedance.
// R12: Driving the power-down pin low returns the block to normal operation.
// R13: Full power-down turns off reference, its buffer, bias and clock.
// R14: Wake-up delay scales with the time spent powered down.
// R15: Register-only standby keeps the reference on for a faster wake-up.
// R16: First-pulse mode disarms after one sync until 0x100 is written again.
`timescale 1ns/10ps
module sample_clock_ctrl
  import clkdiv_pkg::*;
#(
  parameter longint SAMPLE_CLK_HZ = SYS_CLK_HZ,
  parameter int     DIV_MAX       = 8
)
(
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst,
  // Register port
  input  wire reg_req_t  reg_req,
  output logic [7:0]     reg_rdata,
  // Pins
  input  wire logic      sync_pin,
  input  wire logic      powerdown_pin,
  // Conversion clock
  output logic           conv_clk,
  output logic           conv_clk_en,
  output logic           dcs_locked,
  // Power control
  output pwr_ctrl_t      pwr,
  output logic           core_ready
);
  localparam logic DCS_USABLE = (SAMPLE_CLK_HZ >= DCS_MIN_HZ);

  if (DIV_MAX != 8 || SAMPLE_CLK_HZ <= 0)
  begin : g_check
    $error("Unsupported divider or clock parameters");
  end

  state_t q;
  state_t d;

  function automatic logic hit(input reg_req_t r, input logic [8:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  logic                sync_accept;
  logic                pd_req;
  logic                dcs_eff;
  logic [2:0]          half;
  logic                clk_on;
  logic [PD_CNT_W-1:0] wake_load;

  always_comb
  begin
    d = q;
    // Pin synchronisers, level accepted when stages two and three agree
    d.sync_s = {q.sync_s[1:0], sync_pin};                        // R5
    if (q.sync_s[1] == q.sync_s[2])
    begin
      d.sync_lvl = q.sync_s[2];
    end
    d.pd_s = {q.pd_s[1:0], powerdown_pin};
    if (q.pd_s[1] == q.pd_s[2])
    begin
      d.pd_lvl = q.pd_s[2];
    end
    sync_accept = q.sync_s[1] && q.sync_s[2] && !q.sync_lvl
                  && q.sync_ctrl[SYNC_EN_BIT]
                  && (!q.sync_ctrl[SYNC_FIRST_BIT] || q.armed);  // R3
    pd_req  = q.pd_lvl || (q.pwr_mode != PWR_NORMAL);            // R10
    dcs_eff = q.duty_cycle_stabiliser && DCS_USABLE;             // R8
    clk_on  = q.pwr.core_clk_on;
    // Register writes
    if (hit(reg_req, ADDR_SYNC))
    begin
      d.sync_ctrl = reg_req.wdata;
      d.armed     = 1'b1;                                        // R16
    end
    else if (sync_accept && q.sync_ctrl[SYNC_FIRST_BIT])
    begin
      d.armed = 1'b0;                                            // R16
    end
    if (hit(reg_req, ADDR_DCS))
    begin
      d.duty_cycle_stabiliser = reg_req.wdata[DCS_EN_BIT];
    end
    if (hit(reg_req, ADDR_DIVIDE))
    begin
      d.ratio_m1 = reg_req.wdata[DIV_LSB +: 3];
    end
    if (hit(reg_req, ADDR_POWER))
    begin
      d.pwr_mode = pwr_mode_t'(reg_req.wdata[PWR_LSB +: 2]);
    end
    // Register reads
    d.rdata = 8'h00;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        ADDR_SYNC:
        begin
          d.rdata = q.sync_ctrl;
          d.rdata[SYNC_ARMED_BIT] = q.armed;
        end
        ADDR_DCS:
        begin
          d.rdata[DCS_EN_BIT]   = q.duty_cycle_stabiliser;
          d.rdata[DCS_LOCK_BIT] = q.dcs_locked;
        end
        ADDR_DIVIDE: d.rdata[DIV_LSB +: 3] = q.ratio_m1;
        ADDR_POWER:  d.rdata[PWR_LSB +: 2] = q.pwr_mode;
        default:     d.rdata = 8'h00;
      endcase
    end
    // Divider
    if (!clk_on || sync_accept)
    begin
      d.div_cnt = 3'h0;                                          // R4
    end
    else if (q.div_cnt >= q.ratio_m1)
    begin
      d.div_cnt = 3'h0;                                          // R1
    end
    else
    begin
      d.div_cnt = q.div_cnt + 3'h1;                              // R1
    end
    d.conv_clk_en = clk_on && (d.div_cnt == 3'h0);
    half = 3'((4'(q.ratio_m1) + 4'h2) >> 1);
    if (!clk_on)
    begin
      d.conv_clk = 1'b0;
    end
    else if (q.ratio_m1 == 3'h0)
    begin
      d.conv_clk = 1'b1;
    end
    else if (dcs_eff)
    begin
      d.conv_clk = (d.div_cnt < half);                           // R7
    end
    else
    begin
      d.conv_clk = (d.div_cnt == 3'h0);
    end
    // Stabiliser relock timer restarts on any clock setting change
    if (!dcs_eff || !clk_on || hit(reg_req, ADDR_DIVIDE)
        || hit(reg_req, ADDR_DCS))
    begin
      d.lock_cnt   = 8'h00;
      d.dcs_locked = 1'b0;                                       // R8
    end
    else if (32'(q.lock_cnt) >= DCS_RELOCK_CYC - 1)
    begin
      d.dcs_locked = 1'b1;
    end
    else
    begin
      d.lock_cnt = q.lock_cnt + 8'h01;
    end
    // Power state machine
    wake_load = q.pd_time >> (q.down_stby ? WAKE_SHIFT_STBY
                                          : WAKE_SHIFT_FULL);   // R14
    case (q.pstate)
      ST_RUN:
      begin
        if (pd_req)
        begin
          d.pstate    = ST_DOWN;                                 // R10
          d.pd_time   = '0;
          d.down_stby = !q.pd_lvl && (q.pwr_mode == PWR_STANDBY);
        end
      end
      ST_DOWN:
      begin
        d.down_stby = !q.pd_lvl && (q.pwr_mode == PWR_STANDBY);  // R15
        if (q.pd_time != '1)
        begin
          d.pd_time = q.pd_time + 1'b1;                          // R14
        end
        if (!pd_req)
        begin
          d.pstate   = ST_WAKE;                                  // R12
          d.wake_cnt = wake_load;                                // R14
        end
      end
      ST_WAKE:
      begin
        if (pd_req)
        begin
          d.pstate    = ST_DOWN;
          d.pd_time   = '0;
          d.down_stby = !q.pd_lvl && (q.pwr_mode == PWR_STANDBY);
        end
        else if (q.wake_cnt == '0)
        begin
          d.pstate = ST_RUN;                                     // R12
        end
        else
        begin
          d.wake_cnt = q.wake_cnt - 1'b1;
        end
      end
      default: d.pstate = ST_DOWN;
    endcase
    d.pwr.out_oe_n    = (d.pstate != ST_RUN);                    // R11
    d.pwr.core_clk_on = (d.pstate != ST_DOWN);                   // R13
    d.pwr.bias_on     = (d.pstate != ST_DOWN);                   // R13
    d.pwr.ref_buf_on  = (d.pstate != ST_DOWN);                   // R13
    d.pwr.ref_on      = (d.pstate != ST_DOWN) || d.down_stby;    // R15
    d.core_ready      = (d.pstate == ST_RUN);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q                       <= '0;
      q.sync_ctrl             <= SYNC_RESET;
      q.duty_cycle_stabiliser <= DCS_RESET;
      q.ratio_m1              <= DIV_RESET;
      q.pwr_mode              <= PWR_NORMAL;
      q.pstate                <= ST_RUN;
      q.pwr                   <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      q.core_ready            <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata   = q.rdata;
  assign conv_clk    = q.conv_clk;
  assign conv_clk_en = q.conv_clk_en;
  assign dcs_locked  = q.dcs_locked;
  assign pwr         = q.pwr;
  assign core_ready  = q.core_ready;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_div_wrap;
    q.pwr.core_clk_on && q.div_cnt == q.ratio_m1 && !sync_accept
      |=> q.div_cnt == 3'h0;
  endproperty
  a_div_wrap: assert property (p_div_wrap)                       // R1
    else $error("Divider did not wrap at ratio");

  property p_sync_reset;
    q.pwr.core_clk_on && sync_accept |=> q.div_cnt == 3'h0 && conv_clk_en;
  endproperty
  a_sync_reset: assert property (p_sync_reset)                   // R4
    else $error("Sync did not restart the divider");

  property p_sync_delay;
    sync_accept |-> $past(sync_pin, 2) && $past(sync_pin, 3);
  endproperty
  a_sync_delay: assert property (p_sync_delay)                   // R5
    else $error("Sync acted on before synchronisation");

  property p_first_only;
    q.sync_ctrl[SYNC_FIRST_BIT] && !q.armed |-> !sync_accept;
  endproperty
  a_first_only: assert property (p_first_only)                   // R16
    else $error("Disarmed sync still accepted");

  property p_disarm;
    sync_accept && q.sync_ctrl[SYNC_FIRST_BIT] && !reg_req.wr
      |=> !q.armed;
  endproperty
  a_disarm: assert property (p_disarm)                           // R3
    else $error("First-pulse mode did not disarm");

  property p_dcs_half;
    dcs_eff && q.ratio_m1 == 3'h7 && q.pwr.core_clk_on && !sync_accept
      && q.div_cnt == 3'h7 && !reg_req.wr
      |=> conv_clk ##1 (conv_clk || q.div_cnt != 3'h1);
  endproperty
  a_dcs_half: assert property (p_dcs_half)                       // R7
    else $error("Stabilised clock not high for half period");

  property p_dcs_slow;
    !DCS_USABLE |-> !dcs_locked;
  endproperty
  a_dcs_slow: assert property (p_dcs_slow)                       // R8
    else $error("Stabiliser locked below its range");

  property p_pd_enter;
    q.pstate == ST_RUN && pd_req |=> !pwr.core_clk_on && pwr.out_oe_n;
  endproperty
  a_pd_enter: assert property (p_pd_enter)                       // R10
    else $error("Power-down request not honoured");

  property p_hiz;
    q.pstate != ST_RUN |-> pwr.out_oe_n && !core_ready;
  endproperty
  a_hiz: assert property (p_hiz)                                 // R11
    else $error("Outputs driven while not running");

  property p_full_off;
    q.pstate == ST_DOWN && !q.down_stby
      |-> !pwr.ref_on && !pwr.bias_on && !pwr.ref_buf_on;
  endproperty
  a_full_off: assert property (p_full_off)                       // R13
    else $error("Analog blocks on in full power-down");

  property p_wake_len;
    q.pstate == ST_DOWN && !pd_req |=> q.wake_cnt == $past(wake_load);
  endproperty
  a_wake_len: assert property (p_wake_len)                       // R14
    else $error("Wake delay not scaled to down time");

  property p_stby_ref;
    q.pstate != ST_RUN && q.down_stby |-> pwr.ref_on;
  endproperty
  a_stby_ref: assert property (p_stby_ref)                       // R15
    else $error("Reference off in standby");

  property p_resume;
    q.pstate == ST_WAKE && q.wake_cnt == '0 && !pd_req
      |=> core_ready && !pwr.out_oe_n;
  endproperty
  a_resume: assert property (p_resume)                           // R12
    else $error("Did not resume after wake delay");
endmodule : sample_clock_ctrl

// File: bench/sync_source.sv
// Sync pulse and power-down pin source driven from the sample clock
`timescale 1ns/10ps
module sync_source
(
  // Clock
  input  wire logic clk_sys,
  // Pins
  output logic      sync_pin,
  output logic      powerdown_pin
);
  initial
  begin
    sync_pin      = 1'b0;
    powerdown_pin = 1'b0;
  end

  // Pulse launched off the falling edge, three cycles high
  task automatic pulse();
    @(negedge clk_sys);
    sync_pin = 1'b1;
    repeat (3) @(negedge clk_sys);
    sync_pin = 1'b0;
  endtask : pulse

  task automatic pdown(input logic level);
    @(negedge clk_sys);
    powerdown_pin = level;
  endtask : pdown
endmodule : sync_source

// File: bench/sample_clock_ctrl_bench.sv
// Self-checking bench for the sample clock controller
`timescale 1ns/10ps
module sample_clock_ctrl_bench
  import clkdiv_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  reg_req_t    reg_req;
  logic [7:0]  reg_rdata;
  logic        sync_pin;
  logic        powerdown_pin;
  logic        conv_clk;
  logic        conv_clk_en;
  logic        dcs_locked;
  pwr_ctrl_t   pwr;
  logic        core_ready;
  int          error_cnt;
  int          total_checks;
  int          r;
  int          n;
  int          w_full;
  int          w_stby;
  logic [7:0]  d;
  logic [15:0] ens;
  logic [15:0] his;

  sample_clock_ctrl sample_clock_ctrl_i (
    .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sync_pin(sync_pin),
    .powerdown_pin(powerdown_pin), .conv_clk(conv_clk),
    .conv_clk_en(conv_clk_en), .dcs_locked(dcs_locked),
    .pwr(pwr), .core_ready(core_ready)
  );

  sync_source sync_source_i (
    .clk_sys(clk_sys), .sync_pin(sync_pin),
    .powerdown_pin(powerdown_pin)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk_sys);
    reg_req = '0;
  endtask : wr

  task automatic rd(input logic [8:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    v = reg_rdata;
    reg_req = '0;
  endtask : rd

  // Strobe lands after the fourth edge from the pulse rise
  task automatic align(input logic exp);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(16'(conv_clk_en), 16'(exp));
  endtask : align

  task automatic window();
    ens = '0;
    his = '0;
    repeat (840)
    begin
      @(negedge clk_sys);
      ens = ens + 16'(conv_clk_en);
      his = his + 16'(conv_clk);
    end
  endtask : window

  task automatic wait_ready(output int k);
    k = 0;
    while (core_ready !== 1'b1 && k < 2000)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 2000)
    begin
      error_cnt++;
      $display("MISMATCH %0t wake-up never finished", $time);
      end_sim();
    end
  endtask : wait_ready

  initial
  begin
    error_cnt    = 0;
    total_checks = 0;
    rst          = 1'b1;
    reg_req      = '0;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    chk(16'(pwr), 16'h001E);
    chk(16'(core_ready), 16'h0001);
    rd(ADDR_SYNC, d);
    chk(16'(d), 16'h0000);
    wr(9'h0FF, 8'hFF);
    rd(9'h0FF, d);
    chk(16'(d), 16'h0000);
    $display("test reset done");
    wr(ADDR_SYNC, 8'h02);
    for (int i = 0; i < 8; i++)
    begin
      r = i + 1;
      wr(ADDR_DIVIDE, 8'(i));
      wr(ADDR_DCS, {7'h00, r[1]});
      sync_source_i.pulse();
      align(1'b1);
      window();
      chk(ens, 16'(840 / r));
      n = r[1] ? (840 / r) * ((r + 1) / 2) : 840 / r;
      chk(his, 16'(n));
    end
    $display("test divider done");
    wr(ADDR_DCS, 8'h01);
    n = 0;
    while (dcs_locked !== 1'b1 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(16'(n >= 195 && n <= 205), 16'h0001);
    rd(ADDR_DCS, d);
    chk(16'(d), 16'h0003);
    $display("test stabiliser done");
    wr(ADDR_SYNC, 8'h06);
    rd(ADDR_SYNC, d);
    chk(16'(d), 16'h000E);
    sync_source_i.pulse();
    align(1'b1);
    sync_source_i.pulse();
    align(1'b0);
    rd(ADDR_SYNC, d);
    chk(16'(d), 16'h0006);
    $display("test sync modes done");
    wr(ADDR_POWER, 8'h01);
    repeat (3) @(negedge clk_sys);
    chk(16'(pwr), 16'h0001);
    chk(16'(core_ready), 16'h0000);
    repeat (80) @(negedge clk_sys);
    wr(ADDR_POWER, 8'h00);
    wait_ready(w_full);
    wr(ADDR_POWER, 8'h02);
    repeat (3) @(negedge clk_sys);
    chk(16'(pwr), 16'h0011);
    repeat (80) @(negedge clk_sys);
    wr(ADDR_POWER, 8'h00);
    wait_ready(w_stby);
    chk(16'(w_stby < w_full), 16'h0001);
    wr(ADDR_POWER, 8'h01);
    repeat (320) @(negedge clk_sys);
    wr(ADDR_POWER, 8'h00);
    wait_ready(n);
    chk(16'(n > w_full), 16'h0001);
    sync_source_i.pdown(1'b1);
    repeat (8) @(negedge clk_sys);
    chk(16'(pwr), 16'h0001);
    sync_source_i.pdown(1'b0);
    wait_ready(n);
    @(negedge clk_sys);
    chk(16'(pwr), 16'h001E);
    $display("test power done");
    end_sim();
  end
endmodule : sample_clock_ctrl_bench
